//--- rtl/ras_pkg.sv
// Package for the return address stack block: register map, field layout,
// reset values and operation codes.
// Assumes a 32-bit APB slave and a 21-bit program counter.
package ras_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int          PC_W        = 21;
  localparam int          IDX_W       = 5;
  localparam int          DEPTH       = 31;
  localparam logic [4:0]  IDX_MAX     = 5'h1F;
  localparam logic [4:0]  IDX_ZERO    = 5'h00;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0]  ADDR_INDEX  = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_CONFIG = 8'h08;
  localparam logic [7:0]  ADDR_TOP_U  = 8'h0C;
  localparam logic [7:0]  ADDR_TOP_H  = 8'h10;
  localparam logic [7:0]  ADDR_TOP_L  = 8'h14;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          STAT_OVF_BIT = 7;
  localparam int          STAT_UNF_BIT = 6;
  localparam int          CFG_FRE_BIT  = 0;
  localparam logic        FRE_RESET    = 1'b1;
  localparam int          TOP_U_W      = 5;

  // ****************************************
  // Stack operations from the sequencer
  // ****************************************
  // Code zero is idle, so the sequencer can leave the stack untouched.
  typedef enum logic [3:0] {
    RAS_OP_NONE     = 4'h0,
    RAS_OP_CALL     = 4'h1,
    RAS_OP_CALL_IND = 4'h2,
    RAS_OP_INT      = 4'h3,
    RAS_OP_PUSH     = 4'h4,
    RAS_OP_RET      = 4'h5,
    RAS_OP_RETL     = 4'h6,
    RAS_OP_RETI     = 4'h7,
    RAS_OP_POP      = 4'h8
  } ras_op_t;

  localparam logic [3:0]  OP_POPI      = 4'h8;

endpackage : ras_pkg

//--- rtl/ras_stack.sv
// Return address stack with index, top entry windows and fault flags.
// Assumes the sequencer issues at most one operation per cycle on i_op,
// and that i_por_b pulses low on power-on only, alongside i_rst_b.
//
// How it works
// - Index holds values 0 to 31.
// - Any device reset clears the index.
// - Software reads and writes the index.
// - Overflow and underflow flags in status register.
// - Thirty-second push sets overflow flag.
// - Overflow flag sticky until software or power-on.
// - Fault reset on: flag, reset, index zero.
// - Call, indirect call, interrupt entry push.
// - Fault reset off: flag, index held 31.
// - Later pushes overwrite entry 31.
// - Software writing overflow never resets device.
// - Pop returning zero sets underflow flag.
// - Underflow flag sticky until software or power-on.
// - Fault reset on: empty pop resets device.
// - Return, literal return, interrupt return detected.
// - Fault reset off: underflow, no reset.
// - Underflow alone just returns zero address.
// - Top entry via upper, high, low windows.
// - Push stores program counter at new top.
// - Pop decrements index, exposing previous entry.
`timescale 1ns/1ps
module ras_stack
  import ras_pkg::*;
(
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  input  wire logic             i_por_b,
  // Sequencer side
  input  wire ras_op_t          i_op,
  input  wire logic [PC_W-1:0]  i_pc,
  // APB slave
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [7:0]       i_paddr,
  input  wire logic [31:0]      i_pwdata,
  output logic [31:0]           o_prdata,
  output logic                  o_pready,
  output logic                  o_pslverr,
  // Results
  output logic [PC_W-1:0]       o_pop_pc,
  output logic                  o_pop_valid,
  output logic                  o_device_reset,
  output logic [IDX_W-1:0]      o_index,
  output logic                  o_overflow,
  output logic                  o_underflow
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [IDX_W-1:0] return_stack_index;
    logic             stack_fault_reset_enable;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [PC_W-1:0]  pop_pc;
    logic             pop_valid;
    logic             device_reset;
  } ras_state_t;

  // The flags survive a device reset and are cleared by power-on or by a software write of zero only.
  typedef struct packed {
    logic             stack_overflow_flag;
    logic             stack_underflow_flag;
  } ras_flags_t;

  ras_state_t             st;
  ras_state_t             next_st;
  ras_flags_t             fl;
  ras_flags_t             next_fl;
  logic [PC_W-1:0]        mem [1:DEPTH];
  logic                   mem_we;
  logic [IDX_W-1:0]       mem_wa;
  logic [PC_W-1:0]        mem_wd;

  function automatic logic is_push(input ras_op_t op);
    return op == RAS_OP_CALL || op == RAS_OP_CALL_IND || op == RAS_OP_INT ||
           op == RAS_OP_PUSH;
  endfunction : is_push

  function automatic logic is_pop(input ras_op_t op);
    return op == RAS_OP_RET || op == RAS_OP_RETL || op == RAS_OP_RETI ||
           op == ras_op_t'(OP_POPI);
  endfunction : is_pop

  function automatic logic [PC_W-1:0] top_of(input logic [IDX_W-1:0] idx,
                                             input logic [PC_W-1:0] top);
    return (idx == IDX_ZERO) ? '0 : top;
  endfunction : top_of

  function automatic logic reg_mapped(input logic [7:0] a);
    return a == ADDR_INDEX || a == ADDR_STATUS || a == ADDR_CONFIG ||
           a == ADDR_TOP_U || a == ADDR_TOP_H || a == ADDR_TOP_L;
  endfunction : reg_mapped

  logic [PC_W-1:0]        top_val;
  logic                   apb_wr;
  logic                   apb_rd;
  assign top_val = top_of(st.return_stack_index, mem[st.return_stack_index]);
  assign apb_wr  = i_psel && i_penable && i_pwrite;
  assign apb_rd  = i_psel && !i_pwrite;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st              = st;
    next_fl              = fl;
    next_st.pop_valid    = 1'b0;
    next_st.device_reset = 1'b0;
    next_st.pready       = i_psel && !i_penable;
    // Error is decided at setup so it stands beside pready.
    next_st.pslverr      = i_psel && !i_penable && i_pwrite && !reg_mapped(i_paddr);
    mem_we               = 1'b0;
    mem_wa               = st.return_stack_index;
    mem_wd               = i_pc;
    if (is_push(i_op)) begin
      if (st.return_stack_index == IDX_MAX) begin
        next_fl.stack_overflow_flag = 1'b1;
        if (st.stack_fault_reset_enable) begin
          next_st.device_reset       = 1'b1;
          next_st.return_stack_index = IDX_ZERO;
        end else begin
          mem_we = 1'b1;
        end
      end else begin
        next_st.return_stack_index = st.return_stack_index + 5'h01;
        mem_wa = st.return_stack_index + 5'h01;
        mem_we = 1'b1;
      end
    end else if (is_pop(i_op)) begin
      next_st.pop_valid = (i_op != ras_op_t'(OP_POPI));
      next_st.pop_pc    = top_val;
      if (st.return_stack_index != IDX_ZERO) begin
        next_st.return_stack_index = st.return_stack_index - 5'h01;
      end
      if (top_val == '0) begin
        next_fl.stack_underflow_flag = 1'b1;
        next_st.device_reset = st.stack_fault_reset_enable &&
                               st.return_stack_index == IDX_ZERO;
      end
    end
    if (apb_wr) begin
      unique case (i_paddr)
        ADDR_INDEX: next_st.return_stack_index = i_pwdata[IDX_W-1:0];
        ADDR_STATUS: begin
          next_fl.stack_overflow_flag  = i_pwdata[STAT_OVF_BIT] ||
                                         (next_fl.stack_overflow_flag &&
                                          !fl.stack_overflow_flag);
          next_fl.stack_underflow_flag = i_pwdata[STAT_UNF_BIT] ||
                                         (next_fl.stack_underflow_flag &&
                                          !fl.stack_underflow_flag);
        end
        ADDR_CONFIG: next_st.stack_fault_reset_enable = i_pwdata[CFG_FRE_BIT];
        ADDR_TOP_U: begin
          mem_we = st.return_stack_index != IDX_ZERO;
          mem_wa = st.return_stack_index;
          mem_wd = {i_pwdata[TOP_U_W-1:0], top_val[15:0]};
        end
        ADDR_TOP_H: begin
          mem_we = st.return_stack_index != IDX_ZERO;
          mem_wa = st.return_stack_index;
          mem_wd = {top_val[20:16], i_pwdata[7:0], top_val[7:0]};
        end
        ADDR_TOP_L: begin
          mem_we = st.return_stack_index != IDX_ZERO;
          mem_wa = st.return_stack_index;
          mem_wd = {top_val[20:8], i_pwdata[7:0]};
        end
        default: ;
      endcase
    end
    if (apb_rd && !i_penable) begin
      unique case (i_paddr)
        ADDR_INDEX:  next_st.prdata = {27'h0, st.return_stack_index};
        ADDR_STATUS: next_st.prdata = {24'h0, fl.stack_overflow_flag,
                                       fl.stack_underflow_flag, 6'h00};
        ADDR_CONFIG: next_st.prdata = {31'h0, st.stack_fault_reset_enable};
        ADDR_TOP_U:  next_st.prdata = {27'h0, top_val[20:16]};
        ADDR_TOP_H:  next_st.prdata = {24'h0, top_val[15:8]};
        ADDR_TOP_L:  next_st.prdata = {24'h0, top_val[7:0]};
        default:     next_st.prdata = 32'h0000_0000;
      endcase
    end
    if (apb_wr) begin
      next_st.pready = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Reset clears index; flags only on power-on.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st.return_stack_index       <= IDX_ZERO;
      st.stack_fault_reset_enable <= FRE_RESET;
      st.prdata                   <= 32'h0000_0000;
      st.pready                   <= 1'b0;
      st.pslverr                  <= 1'b0;
      st.pop_pc                   <= '0;
      st.pop_valid                <= 1'b0;
      st.device_reset             <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge i_clock or negedge i_por_b) begin
    if (!i_por_b) begin
      fl <= '0;
    end else begin
      fl <= next_fl;
    end
  end

  always_ff @(posedge i_clock) begin
    if (mem_we && mem_wa != IDX_ZERO) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign o_prdata       = st.prdata;
  assign o_pready       = st.pready;
  assign o_pslverr      = st.pslverr;
  assign o_pop_pc       = st.pop_pc;
  assign o_pop_valid    = st.pop_valid;
  assign o_device_reset = st.device_reset;
  assign o_index        = st.return_stack_index;
  assign o_overflow     = fl.stack_overflow_flag;
  assign o_underflow    = fl.stack_underflow_flag;

  // ****************************************
  // Checks
  // ****************************************
  // Enabled overflow resets.
  ovf_reset_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    is_push(i_op) && st.return_stack_index == IDX_MAX && st.stack_fault_reset_enable
    && !apb_wr |=> o_device_reset && o_overflow && o_index == IDX_ZERO)
    else $error("overflow did not reset");
  ovf_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    is_push(i_op) && st.return_stack_index == IDX_MAX && !st.stack_fault_reset_enable
    && !apb_wr |=> !o_device_reset && o_overflow && o_index == IDX_MAX)
    else $error("overflow did not hold");
  push_inc_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    is_push(i_op) && st.return_stack_index < IDX_MAX && !apb_wr
    |=> o_index == $past(st.return_stack_index) + 5'h01)
    else $error("push did not increment");
  pop_dec_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    is_pop(i_op) && st.return_stack_index != IDX_ZERO && !apb_wr
    |=> o_index == $past(st.return_stack_index) - 5'h01)
    else $error("pop did not decrement");
  unf_reset_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    is_pop(i_op) && st.return_stack_index == IDX_ZERO && st.stack_fault_reset_enable
    |=> o_device_reset && o_underflow && o_pop_pc == '0)
    else $error("underflow did not reset");
  unf_quiet_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !st.stack_fault_reset_enable |=> !o_device_reset)
    else $error("reset while disabled");
  ovf_sticky_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_overflow && !apb_wr |=> o_overflow)
    else $error("overflow flag dropped");
  unf_sticky_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_underflow && !apb_wr |=> o_underflow)
    else $error("underflow flag dropped");
  idx_write_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    apb_wr && i_paddr == ADDR_INDEX |=> o_index == $past(i_pwdata[IDX_W-1:0]))
    else $error("index write lost");
  bus_ready_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  bus_error_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_psel && !i_penable && i_pwrite && !reg_mapped(i_paddr) |=> o_pslverr && o_pready)
    else $error("no error on unmapped write");
  pop_zero_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    is_pop(i_op) && st.return_stack_index == IDX_ZERO && !apb_wr
    |=> o_underflow && o_pop_pc == '0)
    else $error("empty pop not flagged");
  sw_quiet_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    apb_wr && i_paddr == ADDR_STATUS && !is_push(i_op) && !is_pop(i_op) |=> !o_device_reset)
    else $error("status write caused reset");
  push_store_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    is_push(i_op) && st.return_stack_index < IDX_MAX && !apb_wr
    |=> top_val == $past(i_pc))
    else $error("pushed value not on top");

endmodule : ras_stack

//--- verif/ras_seq_model.sv
// Sequencer model: drives one stack operation every other cycle and counts fault resets.
// Assumes the bench calls issue from procedural code; the op returns to RAS_OP_NONE after one cycle.
`timescale 1ns/1ps
module ras_seq_model
  import ras_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // Stack side
  input  wire logic        i_device_reset,
  output ras_op_t          o_op,
  output logic [PC_W-1:0]  o_pc
);
  int resets;

  initial begin
    o_op   = RAS_OP_NONE;
    o_pc   = '0;
    resets = 0;
  end

  always @(posedge i_clock) begin
    if (i_rst_b && i_device_reset) begin
      resets <= resets + 1;
    end
  end

  // One op stands for one cycle; the task returns once its effect has settled.
  task automatic issue(input ras_op_t c, input logic [PC_W-1:0] p);
    @(posedge i_clock);
    o_op <= c;
    o_pc <= p;
    @(posedge i_clock);
    o_op <= RAS_OP_NONE;
    @(negedge i_clock);
  endtask : issue
endmodule : ras_seq_model

//--- verif/return_address_stack_bench.sv
// Self-checking bench for the return address stack: APB tasks and op sequences.
// Assumes ras_stack and the sequencer model; op results are sampled at the falling edge, APB read data and error at the rising edge.
`timescale 1ns/1ps
module return_address_stack_bench
  import ras_pkg::*;
;
  localparam logic [PC_W-1:0] PV = 21'h1A5C3;
  logic             i_clock;
  logic             i_rst_b;
  logic             i_por_b;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic             pready;
  logic             pslverr;
  logic             err;
  logic             pop_valid;
  logic             dev_rst;
  logic             ovf;
  logic             unf;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic [31:0]      rd;
  logic [PC_W-1:0]  pop_pc;
  logic [PC_W-1:0]  pc;
  logic [IDX_W-1:0] idx;
  ras_op_t          op;
  ras_op_t          rcode [4] = '{RAS_OP_RET, RAS_OP_RETL, RAS_OP_RETI, ras_op_t'(OP_POPI)};
  ras_op_t          pcode [4] = '{RAS_OP_CALL, RAS_OP_CALL_IND, RAS_OP_INT, RAS_OP_PUSH};
  int               compares = 0;
  int               miscompares = 0;
  int               nrst;

  ras_stack dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_por_b(i_por_b), .i_op(op), .i_pc(pc),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_pop_pc(pop_pc),
    .o_pop_valid(pop_valid), .o_device_reset(dev_rst), .o_index(idx), .o_overflow(ovf),
    .o_underflow(unf));

  ras_seq_model seq (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_device_reset(dev_rst),
    .o_op(op), .o_pc(pc));

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  initial begin
    #100000;
    miscompares++;
    close_out();
  end

  initial begin
    i_rst_b = 1'b0;
    i_por_b = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (16) @(posedge i_clock);
    i_rst_b <= 1'b1;
    i_por_b <= 1'b1;
    apb(1'b0, ADDR_INDEX, 32'h0);
    check("index", rd, 32'h0);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check("fault_en", rd, 32'h1);
    apb(1'b1, 8'h1C, 32'h0);
    check("slverr", 32'(err), 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 31; k++) begin
      seq.issue(pcode[k % 4], 21'(k + 1));
      check("index_up", 32'(idx), 32'(k + 1));
    end
    check("ovf_early", 32'(ovf), 32'h0);
    seq.issue(RAS_OP_PUSH, PV);
    check("index_ovf", 32'(idx), 32'h0);
    check("ovf", 32'(ovf), 32'h1);
    check("dev_rst", 32'(dev_rst), 32'h1);
    $display("test overflow done");
    apb(1'b1, ADDR_CONFIG, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("ovf_clr", 32'(rd[STAT_OVF_BIT]), 32'h0);
    nrst = seq.resets;
    apb(1'b1, ADDR_STATUS, 32'h80);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("ovf_sw", 32'(rd[STAT_OVF_BIT]), 32'h1);
    apb(1'b1, ADDR_STATUS, 32'h0);
    for (int k = 0; k < 31; k++) begin
      seq.issue(pcode[k % 4], 21'(k + 1));
    end
    seq.issue(RAS_OP_INT, PV);
    check("ovf_hold", 32'(ovf), 32'h1);
    apb(1'b0, ADDR_INDEX, 32'h0);
    check("index_hold", rd, 32'h1F);
    apb(1'b0, ADDR_TOP_U, 32'h0);
    check("top_u", rd, 32'(PV[20:16]));
    apb(1'b0, ADDR_TOP_H, 32'h0);
    check("top_h", rd, 32'(PV[15:8]));
    apb(1'b0, ADDR_TOP_L, 32'h0);
    check("top_l", rd, 32'(PV[7:0]));
    check("no_reset", 32'(seq.resets - nrst), 32'h0);
    $display("test full stack done");
    apb(1'b1, ADDR_STATUS, 32'h0);
    nrst = seq.resets;
    for (int j = 0; j < 32; j++) begin
      seq.issue((j == 31) ? RAS_OP_RETI : rcode[j % 4], PV);
      check("index_dn", 32'(idx), (j == 31) ? 32'h0 : 32'(30 - j));
      check("underflow", 32'(unf), 32'(j == 31));
      check("ret_valid", 32'(pop_valid), 32'(j % 4 != 3 || j == 31));
      if (j % 4 != 3 || j == 31) begin
        check("ret_pc", 32'(pop_pc), (j == 0) ? 32'(PV) : 32'((31 - j) % 31));
      end
    end
    repeat (2) @(posedge i_clock);
    check("unf_no_rst", 32'(seq.resets - nrst), 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("unf_sticky", 32'(rd[STAT_UNF_BIT]), 32'h1);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check("cfg_kept", rd, 32'h0);
    $display("test underflow done");
    apb(1'b1, ADDR_CONFIG, 32'h1);
    nrst = seq.resets;
    seq.issue(RAS_OP_RET, PV);
    check("unf_pulse", 32'(dev_rst), 32'h1);
    repeat (4) @(posedge i_clock);
    check("unf_reset", 32'(seq.resets - nrst), 32'h1);
    apb(1'b1, ADDR_INDEX, 32'h10);
    @(negedge i_clock);
    check("index_wr", 32'(idx), 32'h10);
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(negedge i_clock);
    check("index_rst", 32'(idx), 32'h0);
    check("unf_kept", 32'(unf), 32'h1);
    $display("test fault reset done");
    close_out();
  end
endmodule : return_address_stack_bench
